/* design/emm_mapper.sv */
// Functional notes
// - Sixteen ranges checked on every access.
// - Ranges compare on 512-byte blocks only.
// - Five attributes: four route emulation or target, guarded routes neither.
// - Guarded access raises a reported error.
// - Enabled ROM write breaks to monitor.
// - Breakpoint opcode fetch breaks to monitor.
// - Enabled analyzer trigger breaks to monitor.
// - Watchdog holds while monitor runs.
// - Break releases sleep; resume after sleep.
// - Hardware standby request resets the processor.
// - Interrupts held pending during monitor.
// - Reset by command or target input.
// - Six kilobytes reserved for monitor, internal RAM.
// - Internal RAM maps as emulation RAM automatically.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module emm_mapper #(
  parameter int EMEM_BYTES = 131072,
  parameter logic [23:0] IRAM_BASE = 24'hFF0000,
  parameter logic [23:0] IRAM_LAST = 24'hFF0FFF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire emm_pkg::emm_regbus_t reg_in,
  output logic [31:0] reg_rdata,
  // Processor access and routing
  input wire emm_pkg::emm_cpu_acc_t cpu_acc,
  output emm_pkg::emm_route_t route,
  // Break handshake with the processor
  input wire logic brk_ack,
  input wire logic mon_exit,
  input wire logic cpu_lowpower,
  input wire logic ana_trig,
  output logic brk_req,
  output logic lp_release,
  output logic wdt_hold,
  // Interrupts and resets
  input wire logic tgt_irq,
  input wire logic tgt_reset_req,
  input wire logic hw_stby_req,
  output logic cpu_irq,
  output logic cpu_rst,
  output logic irq
);
  import emm_pkg::*;

  localparam logic [23:0] USER_LIM = 24'(EMEM_BYTES - MON_RES_BYTES);

  typedef struct packed {
    emm_mode_t mode;
    logic brk_rom_en;
    logic ana_brk_en;
    logic tgt_rst_en;
    emm_attr_t dflt;
    logic [NUM_EV-1:0] sts;
    logic [NUM_EV-1:0] mask;
    emm_range_t [NUM_RANGES-1:0] rng;
    logic [31:0] rdata;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic cpu_rst;
    emm_route_t route;
    logic brk_req;
    logic lp_release;
    logic wdt_hold;
    logic irq_pend;
    logic cpu_irq;
    logic irq;
  } emm_state_t;

  emm_state_t s_q;
  emm_state_t s_d;
  logic m_hit;
  emm_attr_t m_attr;
  logic in_iram;
  emm_attr_t eff_attr;
  logic brk_now;
  logic [NUM_EV-1:0] ev;
  logic [IDX_W-1:0] rng_idx;
  logic [31:0] rd_val;

  // Range lookup on block number; low nine bits never matter
  emm_range_match u_match (
    .ranges(s_q.rng),
    .dflt_attr(s_q.dflt),
    .blk(cpu_acc.addr[ADDR_W-1:BLK_LSB]),
    .hit(m_hit),
    .attr(m_attr),
    .idx()
  );

  // Internal RAM overrides any user range and uses none of them
  assign in_iram = cpu_acc.addr >= IRAM_BASE && cpu_acc.addr <= IRAM_LAST;
  assign eff_attr = in_iram ? EMM_ERAM : m_attr;
  // Range slot from the offset past the table base, so slot i sits at base plus 8i
  assign rng_idx = IDX_W'((reg_in.addr - OFS_RNG_BASE) >> 3);

  // Hardware events feeding the sticky status
  always_comb begin
    ev = '0;
    ev[EV_GUARD] = cpu_acc.valid && !in_iram && eff_attr == EMM_GRD;
    ev[EV_ROM_WR] = cpu_acc.valid && cpu_acc.write && s_q.brk_rom_en && emm_is_rom(eff_attr);
    ev[EV_SWBP] = cpu_acc.valid && cpu_acc.fetch && cpu_acc.opcode == SWBP_OPCODE;
    ev[EV_ANA] = ana_trig && s_q.ana_brk_en;
    ev[EV_TGT_RST] = tgt_reset_req && s_q.tgt_rst_en;
    ev[EV_HW_STBY] = hw_stby_req;
    brk_now = s_q.mode == EMM_RUN && !s_q.cpu_rst && (ev[EV_ROM_WR] || ev[EV_SWBP] || ev[EV_ANA]);
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_in.addr >= OFS_RNG_BASE && reg_in.addr <= OFS_RNG_LAST) begin
      if (reg_in.addr[2]) begin
        rd_val[RNG_EN_BIT] = s_q.rng[rng_idx].en;
        rd_val[ADDR_W-1:BLK_LSB] = s_q.rng[rng_idx].last;
        rd_val[RNG_ATTR_LSB +: 3] = s_q.rng[rng_idx].attr;
      end else begin
        rd_val[ADDR_W-1:BLK_LSB] = s_q.rng[rng_idx].first;
      end
    end else begin
      case (reg_in.addr)
        OFS_CTRL: begin
          rd_val[CTRL_BRK_ROM] = s_q.brk_rom_en;
          rd_val[CTRL_ANA_BRK] = s_q.ana_brk_en;
          rd_val[CTRL_TGT_RST] = s_q.tgt_rst_en;
          rd_val[CTRL_DFLT_LSB +: 3] = s_q.dflt;
        end
        OFS_STATUS: rd_val[NUM_EV-1:0] = s_q.sts;
        OFS_MASK: rd_val[NUM_EV-1:0] = s_q.mask;
        OFS_STATE: rd_val[4:0] = {s_q.irq_pend, s_q.cpu_rst, m_hit, s_q.mode};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.rdata = reg_in.rd ? rd_val : 32'h0000_0000;
    s_d.brk_req = 1'b0;
    s_d.lp_release = 1'b0;
    // Register writes
    if (reg_in.wr) begin
      if (reg_in.addr >= OFS_RNG_BASE && reg_in.addr <= OFS_RNG_LAST) begin
        if (reg_in.addr[2]) begin
          s_d.rng[rng_idx].en = reg_in.wdata[RNG_EN_BIT];
          s_d.rng[rng_idx].last = reg_in.wdata[ADDR_W-1:BLK_LSB];
          s_d.rng[rng_idx].attr = emm_attr_t'(reg_in.wdata[RNG_ATTR_LSB +: 3]);
        end else begin
          s_d.rng[rng_idx].first = reg_in.wdata[ADDR_W-1:BLK_LSB];
        end
      end else begin
        case (reg_in.addr)
          OFS_CTRL: begin
            s_d.brk_rom_en = reg_in.wdata[CTRL_BRK_ROM];
            s_d.ana_brk_en = reg_in.wdata[CTRL_ANA_BRK];
            s_d.tgt_rst_en = reg_in.wdata[CTRL_TGT_RST];
            s_d.dflt = emm_attr_t'(reg_in.wdata[CTRL_DFLT_LSB +: 3]);
          end
          OFS_MASK: s_d.mask = reg_in.wdata[NUM_EV-1:0];
          default: s_d.mask = s_q.mask;
        endcase
      end
    end
    // Write-one-to-clear, but a new event in the same cycle wins
    if (reg_in.wr && reg_in.addr == OFS_STATUS) begin
      s_d.sts = s_q.sts & ~reg_in.wdata[NUM_EV-1:0];
    end
    s_d.sts = s_d.sts | ev;
    // Routing of the access
    s_d.route.guard_err = ev[EV_GUARD];
    s_d.route.emul_sel = cpu_acc.valid && emm_is_emul(eff_attr);
    s_d.route.tgt_sel = cpu_acc.valid && (eff_attr == EMM_TRAM || eff_attr == EMM_TROM);
    s_d.route.emem_addr = cpu_acc.addr;
    if (in_iram) begin
      s_d.route.emem_addr = USER_LIM + (cpu_acc.addr - IRAM_BASE);
    end else if (cpu_acc.valid && emm_is_emul(eff_attr) && cpu_acc.addr >= USER_LIM) begin
      // User ranges may not reach the reserved top of emulation memory
      s_d.route.emul_sel = 1'b0;
      s_d.route.guard_err = 1'b1;
      s_d.sts[EV_GUARD] = 1'b1;
    end
    // Break sequencing
    case (s_q.mode)
      EMM_RUN: begin
        if (brk_now) begin
          s_d.mode = EMM_BRK;
          s_d.lp_release = cpu_lowpower;
        end
      end
      EMM_BRK: begin
        if (brk_ack) begin
          s_d.mode = EMM_MON;
        end
      end
      EMM_MON: begin
        if (mon_exit) begin
          s_d.mode = EMM_RUN;
        end
      end
      default: s_d.mode = EMM_RUN;
    endcase
    // Processor reset: command, target input or hardware standby request
    if ((reg_in.wr && reg_in.addr == OFS_CTRL && reg_in.wdata[CTRL_RST_CMD]) ||
        ev[EV_TGT_RST] || ev[EV_HW_STBY]) begin
      s_d.rst_cnt = RST_CNT_W'(RST_CYCLES);
    end else if (s_q.rst_cnt != '0) begin
      s_d.rst_cnt = s_q.rst_cnt - 1'b1;
    end
    s_d.cpu_rst = s_d.rst_cnt != '0;
    if (s_d.cpu_rst) begin
      s_d.mode = EMM_RUN;
      s_d.irq_pend = 1'b0;
      s_d.lp_release = 1'b0;
    end
    s_d.brk_req = s_d.mode == EMM_BRK;
    s_d.wdt_hold = s_d.mode != EMM_RUN;
    // Interrupts during monitor wait for the return to user code
    if (tgt_irq && s_d.mode != EMM_RUN && !s_d.cpu_rst) begin
      s_d.irq_pend = 1'b1;
    end else if (s_d.mode == EMM_RUN && s_q.cpu_irq) begin
      s_d.irq_pend = 1'b0;
    end
    s_d.cpu_irq = s_d.mode == EMM_RUN && !s_d.cpu_rst && (tgt_irq || s_q.irq_pend);
    s_d.irq = |(s_d.sts & s_d.mask);
  end

  // State register; ranges come up disabled so the default applies
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.dflt <= emm_attr_t'(DFLT_ATTR_RST);
      s_q.mask <= MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = s_q.rdata;
  assign route = s_q.route;
  assign brk_req = s_q.brk_req;
  assign lp_release = s_q.lp_release;
  assign wdt_hold = s_q.wdt_hold;
  assign cpu_irq = s_q.cpu_irq;
  assign cpu_rst = s_q.cpu_rst;
  assign irq = s_q.irq;

  // Checks on the mapping, break, watchdog, reset and interrupt behaviour
  AST_GUARD_FLAG: assert property (@(posedge core_clk) disable iff (reset)
    ev[EV_GUARD] |=> route.guard_err && s_q.sts[EV_GUARD] && !route.emul_sel && !route.tgt_sel)
    else $error("guarded access not flagged");

  AST_ROM_BREAK: assert property (@(posedge core_clk) disable iff (reset)
    (s_q.mode == EMM_RUN && !s_q.cpu_rst && ev[EV_ROM_WR] && !ev[EV_TGT_RST] && !ev[EV_HW_STBY])
    |=> brk_req && s_q.mode == EMM_BRK)
    else $error("ROM write did not break");

  AST_SWBP_BREAK: assert property (@(posedge core_clk) disable iff (reset)
    (s_q.mode == EMM_RUN && !s_q.cpu_rst && cpu_acc.valid && cpu_acc.fetch &&
     cpu_acc.opcode == SWBP_OPCODE && !ev[EV_TGT_RST] && !ev[EV_HW_STBY]) |=> brk_req)
    else $error("breakpoint opcode did not break");

  AST_ANA_OFF: assert property (@(posedge core_clk) disable iff (reset)
    (s_q.mode == EMM_RUN && !s_q.ana_brk_en && !cpu_acc.valid) |=> !brk_req)
    else $error("analyzer break while disabled");

  AST_WDT_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    ((brk_req || s_q.mode == EMM_MON) && !mon_exit) |=> (wdt_hold || cpu_rst))
    else $error("watchdog not held in monitor");

  AST_WAKE: assert property (@(posedge core_clk) disable iff (reset)
    (brk_now && cpu_lowpower && !ev[EV_TGT_RST] && !ev[EV_HW_STBY]) |=> lp_release ##1 !lp_release)
    else $error("low-power state not released on break");

  AST_STBY_RESET: assert property (@(posedge core_clk) disable iff (reset)
    $rose(hw_stby_req) |=> cpu_rst [*4])
    else $error("standby request did not reset the processor");

  AST_IRQ_DEFER: assert property (@(posedge core_clk) disable iff (reset)
    (wdt_hold || cpu_rst) |-> !cpu_irq)
    else $error("interrupt delivered during monitor");

  AST_IRAM_MAP: assert property (@(posedge core_clk) disable iff (reset)
    (cpu_acc.valid && in_iram) |=> route.emul_sel && !route.guard_err && route.emem_addr >= USER_LIM)
    else $error("internal RAM not mapped to reserved emulation memory");

  COV_SWBP: cover property (@(posedge core_clk) disable iff (reset)
    ev[EV_SWBP] ##1 brk_req ##[1:20] s_q.mode == EMM_MON);
  COV_RETURN: cover property (@(posedge core_clk) disable iff (reset)
    s_q.mode == EMM_MON && mon_exit ##1 s_q.mode == EMM_RUN);
  COV_GUARD: cover property (@(posedge core_clk) disable iff (reset) ev[EV_GUARD] ##1 irq);
  COV_DEFER: cover property (@(posedge core_clk) disable iff (reset) s_q.irq_pend ##[1:50] cpu_irq);

endmodule // emm_mapper
`default_nettype wire

/* design/emm_pkg.sv */
package emm_pkg;

  // Processor address space and range granularity
  localparam int ADDR_W = 24;
  localparam int BLK_LSB = 9;
  localparam int BLK_W = ADDR_W - BLK_LSB;
  localparam int NUM_RANGES = 16;
  localparam int IDX_W = 4;
  localparam logic [15:0] SWBP_OPCODE = 16'h5770;
  localparam int MON_RES_BYTES = 6144;

  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  localparam logic [7:0] OFS_RNG_BASE = 8'h40;
  localparam logic [7:0] OFS_RNG_LAST = 8'hBC;

  // Control register fields
  localparam int CTRL_BRK_ROM = 0;
  localparam int CTRL_ANA_BRK = 1;
  localparam int CTRL_TGT_RST = 2;
  localparam int CTRL_DFLT_LSB = 4;
  localparam int CTRL_RST_CMD = 8;

  // Range word fields: low word holds the first block, high word the last
  localparam int RNG_EN_BIT = 31;
  localparam int RNG_ATTR_LSB = 0;

  // Status and mask bit positions
  localparam int NUM_EV = 6;
  localparam int EV_GUARD = 0;
  localparam int EV_ROM_WR = 1;
  localparam int EV_SWBP = 2;
  localparam int EV_ANA = 3;
  localparam int EV_TGT_RST = 4;
  localparam int EV_HW_STBY = 5;

  // Reset values
  localparam logic [NUM_EV-1:0] MASK_RST = 6'h00;
  localparam logic [2:0] DFLT_ATTR_RST = 3'h4;

  // Emulation processor reset pulse length
  localparam int CLK_PERIOD_NS = 50;
  localparam int RST_PULSE_NS = 200;
  localparam int RST_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 3;

  typedef enum logic [2:0] {
    EMM_ERAM = 3'h0,
    EMM_EROM = 3'h1,
    EMM_TRAM = 3'h2,
    EMM_TROM = 3'h3,
    EMM_GRD = 3'h4
  } emm_attr_t;

  // Gray along run -> break -> monitor; monitor -> run flips both bits
  typedef enum logic [1:0] {
    EMM_RUN = 2'h0,
    EMM_BRK = 2'h1,
    EMM_MON = 2'h3
  } emm_mode_t;

  typedef struct packed {
    logic en;
    logic [BLK_W-1:0] first;
    logic [BLK_W-1:0] last;
    emm_attr_t attr;
  } emm_range_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } emm_regbus_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [ADDR_W-1:0] addr;
    logic [15:0] opcode;
  } emm_cpu_acc_t;

  typedef struct packed {
    logic emul_sel;
    logic tgt_sel;
    logic guard_err;
    logic [ADDR_W-1:0] emem_addr;
  } emm_route_t;

  function automatic logic emm_is_rom(input emm_attr_t a);
    return (a == EMM_EROM) || (a == EMM_TROM);
  endfunction

  function automatic logic emm_is_emul(input emm_attr_t a);
    return (a == EMM_ERAM) || (a == EMM_EROM);
  endfunction

endpackage

/* design/emm_range_match.sv */
`timescale 1ns/1ps
`default_nettype none
module emm_range_match (
  // Range table
  input wire emm_pkg::emm_range_t [emm_pkg::NUM_RANGES-1:0] ranges,
  input wire emm_pkg::emm_attr_t dflt_attr,
  // Block number of the access
  input wire logic [emm_pkg::BLK_W-1:0] blk,
  // Result
  output logic hit,
  output emm_pkg::emm_attr_t attr,
  output logic [emm_pkg::IDX_W-1:0] idx
);
  import emm_pkg::*;

  // Downward scan so the lowest matching index wins on overlap
  always_comb begin
    hit = 1'b0;
    attr = dflt_attr;
    idx = '0;
    for (int i = NUM_RANGES - 1; i >= 0; i--) begin
      if (ranges[i].en && blk >= ranges[i].first && blk <= ranges[i].last) begin
        hit = 1'b1;
        attr = ranges[i].attr;
        idx = IDX_W'(i);
      end
    end
  end

endmodule // emm_range_match
`default_nettype wire

/* verification/emm_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Processor side of the break handshake
module emm_cpu_model #(
  parameter int ACK_DLY = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Handshake with the mapper
  input wire logic brk_req,
  input wire logic exit_go,
  output logic brk_ack,
  output logic mon_exit
);
  int cnt_q;
  // Ack a break late on purpose, so the request must hold; leave on command
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 0;
      brk_ack <= 1'b0;
      mon_exit <= 1'b0;
    end else begin
      brk_ack <= brk_req && (cnt_q == ACK_DLY);
      cnt_q <= (brk_req && cnt_q < ACK_DLY) ? cnt_q + 1 : 0;
      mon_exit <= exit_go;
    end
  end
  // No outside bus master here, so emulation memory is never a DMA target
endmodule // emm_cpu_model
`default_nettype wire

/* verification/emm_mapper_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module emm_mapper_bench;
  import emm_pkg::*;
  logic core_clk, reset, brk_ack, mon_exit, cpu_lowpower, ana_trig, brk_req, lp_release, wdt_hold;
  logic tgt_irq, tgt_reset_req, hw_stby_req, cpu_irq, cpu_rst, irq, exit_go;
  emm_regbus_t reg_in;
  logic [31:0] reg_rdata;
  emm_cpu_acc_t cpu_acc;
  emm_route_t route;
  int fail_count = 0;
  int cmp_count = 0;
  int lp_cnt = 0;

  emm_mapper i_dut (.core_clk(core_clk), .reset(reset), .reg_in(reg_in), .reg_rdata(reg_rdata),
    .cpu_acc(cpu_acc), .route(route), .brk_ack(brk_ack), .mon_exit(mon_exit),
    .cpu_lowpower(cpu_lowpower), .ana_trig(ana_trig), .brk_req(brk_req), .lp_release(lp_release),
    .wdt_hold(wdt_hold), .tgt_irq(tgt_irq), .tgt_reset_req(tgt_reset_req), .hw_stby_req(hw_stby_req),
    .cpu_irq(cpu_irq), .cpu_rst(cpu_rst), .irq(irq));
  emm_cpu_model i_cpu (.core_clk(core_clk), .reset(reset), .brk_req(brk_req), .exit_go(exit_go),
    .brk_ack(brk_ack), .mon_exit(mon_exit));

  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  // Count release pulses away from the edge
  always @(negedge core_clk) if (lp_release === 1'b1) lp_cnt++;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    reg_in <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge core_clk);
    reg_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk);
    reg_in <= '0;
    #1;
    chk(reg_rdata & msk, exp);
  endtask
  task automatic rng(input int i, input logic [23:0] f, input logic [23:0] l, input emm_attr_t at);
    wr(OFS_RNG_BASE + 8'(i * 8), {8'h00, f[23:9], 9'h000});
    wr(OFS_RNG_BASE + 8'(i * 8 + 4), {1'b1, 7'h00, l[23:9], 6'h00, at});
  endtask
  // One access; route is checked in the cycle after it
  task automatic acc(input logic w, input logic f, input logic [23:0] a, input logic [15:0] op,
    input logic [2:0] exp);
    @(posedge core_clk);
    cpu_acc <= '{valid: 1'b1, write: w, fetch: f, addr: a, opcode: op};
    @(posedge core_clk);
    cpu_acc <= '0;
    #1;
    chk({route.emul_sel, route.tgt_sel, route.guard_err}, exp);
  endtask
  // Break raised, processor acks late, monitor mode seen
  task automatic brk_cycle();
    chk({brk_req, wdt_hold}, 2'b11);
    repeat (20) if (brk_req === 1'b1) tick();
    rd(OFS_STATE, 32'h3, 32'h3);
    chk(wdt_hold, 1'b1);
  endtask
  task automatic leave();
    @(posedge core_clk);
    exit_go <= 1'b1;
    @(posedge core_clk);
    exit_go <= 1'b0;
    repeat (10) if (wdt_hold === 1'b1) tick();
    chk(wdt_hold, 1'b0);
  endtask
  // Count how long the processor reset stays up
  task automatic rst_len(input int exp);
    int n;
    n = 0;
    #1;
    while (cpu_rst === 1'b1 && n < 10) begin
      n++;
      tick();
    end
    chk(n, exp);
  endtask

  // Watchdog for a hung handshake
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    reg_in = '0;
    cpu_acc = '0;
    {cpu_lowpower, ana_trig, tgt_irq, tgt_reset_req, hw_stby_req, exit_go} = '0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(OFS_CTRL, 32'h40, '1);
    rd(OFS_MASK, 32'h0, '1);
    rd(8'h10, 32'h0, '1);
    $display("test reset values done");
    rng(0, 24'h000000, 24'h00FFFF, EMM_ERAM);
    rng(1, 24'h000000, 24'h0001FF, EMM_GRD);
    rng(2, 24'h200000, 24'h2003FF, EMM_TROM);
    rng(3, 24'h010000, 24'h01FFFF, EMM_EROM);
    rng(15, 24'h100000, 24'h1001FF, EMM_TRAM);
    // Upper-half slot overlapping slot 0; slot 0 must still win
    rng(8, 24'h000000, 24'h0001FF, EMM_TRAM);
    acc(1'b0, 1'b0, 24'h0001FF, 16'h0, 3'b100);
    acc(1'b0, 1'b0, 24'h01E7FF, 16'h0, 3'b100);
    acc(1'b0, 1'b0, 24'h01E800, 16'h0, 3'b001);
    acc(1'b0, 1'b0, 24'h020000, 16'h0, 3'b001);
    acc(1'b0, 1'b0, 24'h1001FF, 16'h0, 3'b010);
    acc(1'b0, 1'b0, 24'h200200, 16'h0, 3'b010);
    acc(1'b0, 1'b0, 24'h010000, 16'h0, 3'b100);
    acc(1'b0, 1'b0, 24'hFF0800, 16'h0, 3'b100);
    chk(route.emem_addr, 24'h01F000);
    rd(OFS_STATUS, 32'h1, 32'h1);
    chk(irq, 1'b0);
    wr(OFS_MASK, 32'h1);
    tick();
    chk(irq, 1'b1);
    wr(OFS_STATUS, 32'h1);
    tick();
    chk(irq, 1'b0);
    wr(OFS_CTRL, 32'h20);
    acc(1'b0, 1'b0, 24'h020000, 16'h0, 3'b010);
    $display("test mapping done");
    wr(OFS_CTRL, 32'h43);
    acc(1'b1, 1'b0, 24'h200000, 16'h0, 3'b010);
    brk_cycle();
    @(posedge core_clk);
    tgt_irq <= 1'b1;
    @(posedge core_clk);
    tgt_irq <= 1'b0;
    tick();
    chk(cpu_irq, 1'b0);
    leave();
    chk(cpu_irq, 1'b1);
    tick();
    chk(cpu_irq, 1'b1);
    tick();
    chk(cpu_irq, 1'b0);
    rd(OFS_STATUS, 32'h2, 32'h2);
    $display("test rom write break done");
    acc(1'b0, 1'b1, 24'h001002, 16'h5771, 3'b100);
    chk(brk_req, 1'b0);
    @(posedge core_clk);
    cpu_lowpower <= 1'b1;
    acc(1'b0, 1'b1, 24'h001000, SWBP_OPCODE, 3'b100);
    brk_cycle();
    @(posedge core_clk);
    cpu_lowpower <= 1'b0;
    leave();
    chk(lp_cnt, 1);
    $display("test software break done");
    @(posedge core_clk);
    ana_trig <= 1'b1;
    @(posedge core_clk);
    ana_trig <= 1'b0;
    #1;
    brk_cycle();
    leave();
    wr(OFS_CTRL, 32'h41);
    @(posedge core_clk);
    ana_trig <= 1'b1;
    @(posedge core_clk);
    ana_trig <= 1'b0;
    tick();
    chk(brk_req, 1'b0);
    chk(lp_cnt, 1);
    $display("test analyzer break done");
    wr(OFS_CTRL, 32'h141);
    rst_len(4);
    @(posedge core_clk);
    hw_stby_req <= 1'b1;
    @(posedge core_clk);
    hw_stby_req <= 1'b0;
    rst_len(4);
    @(posedge core_clk);
    tgt_reset_req <= 1'b1;
    @(posedge core_clk);
    tgt_reset_req <= 1'b0;
    rst_len(0);
    wr(OFS_CTRL, 32'h44);
    @(posedge core_clk);
    tgt_reset_req <= 1'b1;
    @(posedge core_clk);
    tgt_reset_req <= 1'b0;
    rst_len(4);
    $display("test reset sources done");
    tally_and_finish();
  end
endmodule // emm_mapper_bench
`default_nettype wire
